// ==== host_cmd_model.sv ====
// Purpose: host side model issuing command transactions to the device
// Assumes: one transaction per call, strobe held for one cycle
// Notes:   released data lines show inverted garbage, never the last value
module host_cmd_model (
  input  wire logic        ref_clk,
  output      logic        cmd_valid,
  output      logic        cmd_write,
  output      logic        cmd_word,
  output      logic [7:0]  cmd_code,
  output      logic [15:0] cmd_wdata,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_word  = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // one strobe; status places are written on every call, 1 ns after the edge that drops the strobe
  task automatic xfer(input logic wr, input logic wd, input logic [7:0] code,
                      input logic [15:0] data, output logic vld, output logic [15:0] rd);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_word  <= wd;
    cmd_code  <= code;
    cmd_wdata <= data;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    cmd_code  <= ~code;
    cmd_wdata <= ~data;
    #1;
    vld = rsp_valid;
    rd  = rsp_data;
  endtask
endmodule

// ==== rise_time_quantizer.sv ====
// Purpose: map a requested rise-time mantissa to the nearest supported setting
// Assumes: mantissa counts units of 1/16 ms (exponent fixed at minus four)
// Notes:   zero is passed through as the no-ramp request
module rise_time_quantizer (
  input  wire logic [4:0] req_mant,
  output      logic [4:0] snapped_mant,
  output      logic [2:0] setting_idx,
  output      logic       no_ramp,
  output      logic       was_changed
);

  // supported settings in 1/16 ms: 0.6,0.9,1.2,1.8,2.7,4.2,6.0,9.0 ms
  // 9.0 ms would need 144, beyond five bits, so the top table entries saturate at 31
  function automatic logic [4:0] tbl(input logic [2:0] i);
    case (i)
      3'h0:    tbl = 5'h0a;
      3'h1:    tbl = 5'h0e;
      3'h2:    tbl = 5'h13;
      3'h3:    tbl = 5'h1d;
      default: tbl = 5'h1f;
    endcase
  endfunction

  logic [2:0] best;
  logic [5:0] best_err;
  logic [5:0] err;

  // nearest table entry, first hit wins on ties
  always_comb begin
    best     = 3'h0;
    best_err = 6'h3f;
    err      = 6'h00;
    for (int i = 0; i < ssfault_pkg::RISE_SETTINGS; i++) begin
      err = (req_mant > tbl(3'(i))) ? 6'(req_mant - tbl(3'(i)))
                                     : 6'(tbl(3'(i)) - req_mant);
      if (err < best_err) begin
        best     = 3'(i);
        best_err = err;
      end
    end
  end

  assign no_ramp      = (req_mant == 5'h00);
  assign setting_idx  = no_ramp ? 3'h0 : best;
  assign snapped_mant = no_ramp ? 5'h00 : tbl(best);
  assign was_changed  = !no_ramp && (snapped_mant != req_mant);

endmodule

// ==== softstart_time_and_fault_status.sv ====
// Purpose: rise-time command register and fault status registers
// Assumes: cmd port is fed one transaction per strobe by the serial front end
// Notes:   reset default mantissa is kept as written even if off-table
module softstart_time_and_fault_status (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic        cmd_word,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        converter_enabled,
  input  wire logic        power_good,
  input  wire logic        output_voltage_alert_flag_above_ov_trip,
  input  wire logic        output_voltage_alert_flag_below_uv_trip,
  input  wire logic        output_voltage_alert_flag_warning,
  input  wire logic        output_overcurrent_flag_fault,
  input  wire logic        output_overcurrent_flag_warning,
  input  wire logic        input_undervoltage_flag_fault,
  input  wire logic        temp_fault,
  input  wire logic        temp_warning,
  input  wire logic        comm_fault,
  input  wire logic        other_fault,
  output      logic        rsp_valid,
  output      logic [15:0] rsp_data,
  output      logic [15:0] rise_time_word,
  output      logic [2:0]  rise_setting,
  output      logic        rise_no_ramp,
  output      logic        nvm_save,
  output      logic [15:0] nvm_save_data,
  output      logic [7:0]  comm_fault_detail,
  output      logic        smbalert_n_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  // the strobe is passed in, so each continuous assignment below
  // re-evaluates when the strobe moves and not only when the code does
  function automatic logic hit(input logic       vld,
                               input logic [7:0] code,
                               input logic [7:0] want);
    hit = vld && (code == want);
  endfunction

  wire wr_rise   = hit(cmd_valid, cmd_code, ssfault_pkg::CMD_RISE_TIME) && cmd_write;
  wire rd_rise   = hit(cmd_valid, cmd_code, ssfault_pkg::CMD_RISE_TIME) && !cmd_write;
  wire rd_sum    = hit(cmd_valid, cmd_code, ssfault_pkg::CMD_SUMMARY) && !cmd_write;
  wire rd_vf     = hit(cmd_valid, cmd_code, ssfault_pkg::CMD_OUTPUT_VOLTAGE_ALERT_FLAG_FAULTS) && !cmd_write;
  wire do_clear  = hit(cmd_valid, cmd_code, ssfault_pkg::CMD_CLEAR_FAULTS);
  // writes to status codes fall through here and change nothing
  wire do_save   = (hit(cmd_valid, cmd_code, ssfault_pkg::CMD_SAVE_ALL) ||
                    hit(cmd_valid, cmd_code, ssfault_pkg::CMD_SAVE_CODE));

  ////////////////////////////////////////////////////////////////////////////
  // rise-time register

  logic [4:0] rise_mant_ff;
  logic [4:0] nxt_rise_mant;
  logic [4:0] snapped;
  logic [2:0] snap_idx;
  logic       snap_zero;
  logic       snap_changed;
  logic       bad_exp;

  rise_time_quantizer u_quant (
    .req_mant     (cmd_wdata[4:0]),
    .snapped_mant (snapped),
    .setting_idx  (snap_idx),
    .no_ramp      (snap_zero),
    .was_changed  (snap_changed)
  );

  // exponent other than minus four, or set upper mantissa bits, is invalid data
  assign bad_exp       = (cmd_wdata[15:11] != ssfault_pkg::RISE_EXPONENT) ||
                         (cmd_wdata[10:5] != 6'h00);
  assign nxt_rise_mant = wr_rise ? snapped : rise_mant_ff;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rise_mant_ff <= ssfault_pkg::RISE_RESET_MANT;
    end else begin
      rise_mant_ff <= nxt_rise_mant;
    end
  end

  // the reset word carries a one just above the writable field; it reads back
  // only until the host first writes the rise time, after that it is zero
  logic rise_default_ff;
  logic nxt_rise_default;

  assign nxt_rise_default = rise_default_ff && !wr_rise;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rise_default_ff <= 1'b1;
    end else begin
      rise_default_ff <= nxt_rise_default;
    end
  end

  // exponent and upper mantissa bits 10:6 are constants, never stored; bit 5 is the stored reset-default flag
  wire [15:0] rise_word = {ssfault_pkg::RISE_EXPONENT, 5'h00, rise_default_ff,
                           rise_mant_ff};

  ////////////////////////////////////////////////////////////////////////////
  // sticky status flags; set beats a same-cycle clear so no event is lost

  logic [10:0] flags_ff;
  logic [10:0] nxt_flags;
  logic [10:0] raw_ev;
  logic        invalid_wr;

  assign invalid_wr = wr_rise && (bad_exp || snap_changed);

  // flag order: ov, oc, vinuv, temp, cml, other, output_voltage_alert_flag_any, iout_any, vf_ov, vf_uv, inv
  assign raw_ev = {invalid_wr,
                   output_voltage_alert_flag_below_uv_trip,
                   output_voltage_alert_flag_above_ov_trip,
                   output_overcurrent_flag_fault | output_overcurrent_flag_warning,
                   output_voltage_alert_flag_above_ov_trip | output_voltage_alert_flag_below_uv_trip | output_voltage_alert_flag_warning,
                   other_fault | output_voltage_alert_flag_below_uv_trip | output_overcurrent_flag_warning,
                   comm_fault | invalid_wr,
                   temp_fault | temp_warning,
                   input_undervoltage_flag_fault,
                   output_overcurrent_flag_fault,
                   output_voltage_alert_flag_above_ov_trip};
  assign nxt_flags = raw_ev | (do_clear ? 11'h000 : flags_ff);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_ff <= 11'h000;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read views

  logic [7:0] sum_lo;
  logic [7:0] sum_hi;
  logic [7:0] vf_byte;

  // off and power-good bits follow live levels, not latched
  assign sum_lo = {1'b0, !converter_enabled, flags_ff[0], flags_ff[1], flags_ff[2],
                   flags_ff[3], flags_ff[4], flags_ff[5]};
  assign sum_hi = {flags_ff[6], flags_ff[7], 2'b00, !power_good, 3'b000};
  assign vf_byte = {flags_ff[8], 2'b00, flags_ff[9], 4'h0};

  wire [15:0] rd_mux = rd_rise ? rise_word :
                       rd_sum  ? (cmd_word ? {sum_hi, sum_lo} : {8'h00, sum_lo}) :
                       rd_vf   ? {8'h00, vf_byte} : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  logic        rsp_valid_ff;
  logic [15:0] rsp_data_ff;
  logic [15:0] rise_word_ff;
  logic [2:0]  setting_ff;
  logic        no_ramp_ff;
  logic        save_ff;
  logic [15:0] save_data_ff;
  logic        alert_ff;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff  <= 16'h0000;
      rise_word_ff <= ssfault_pkg::RISE_RESET_WORD;
      setting_ff   <= 3'h4; // default 2.7 ms
      no_ramp_ff   <= 1'b0;
      save_ff      <= 1'b0;
      save_data_ff <= 16'h0000;
    end else begin
      rsp_valid_ff <= rd_rise | rd_sum | rd_vf;
      rsp_data_ff  <= rd_mux;
      rise_word_ff <= rise_word;
      setting_ff   <= wr_rise ? snap_idx : setting_ff;
      no_ramp_ff   <= (rise_mant_ff == 5'h00);
      save_ff      <= do_save;
      save_data_ff <= do_save ? rise_word : save_data_ff;
    end
  end

  // alert pin is open drain: oe low means pulled low
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      alert_ff <= 1'b1;
    end else begin
      alert_ff <= !(nxt_flags[10]);
    end
  end

  assign rsp_valid         = rsp_valid_ff;
  assign rsp_data          = rsp_data_ff;
  assign rise_time_word    = rise_word_ff;
  assign rise_setting      = setting_ff; // ramp stage adds ~15% on its own
  assign rise_no_ramp      = no_ramp_ff;
  assign nvm_save          = save_ff;
  assign nvm_save_data     = save_data_ff;
  assign comm_fault_detail = {1'b0, flags_ff[10], 6'h00};
  assign smbalert_n_oe     = alert_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_rise_fixed;
    @(posedge ref_clk) disable iff (!rst_b)
      rise_time_word[15:6] == {ssfault_pkg::RISE_EXPONENT, 5'h00};
  endproperty
  a_rise_fixed: assert property (p_rise_fixed) else $error("rise word fixed bits wrong");

  property p_ov_latch;
    @(posedge ref_clk) disable iff (!rst_b)
      output_voltage_alert_flag_above_ov_trip ##1 !do_clear[*2] |-> flags_ff[8] && flags_ff[0];
  endproperty
  a_ov_latch: assert property (p_ov_latch) else $error("ov flag not latched");

  property p_uv_sets_other;
    @(posedge ref_clk) disable iff (!rst_b)
      output_voltage_alert_flag_below_uv_trip |=> flags_ff[9] && flags_ff[5];
  endproperty
  a_uv_sets_other: assert property (p_uv_sets_other) else $error("uv flags missing");

  property p_sum_read;
    @(posedge ref_clk) disable iff (!rst_b)
      rd_sum && !cmd_word |=> rsp_valid && rsp_data[15:7] == 9'h000;
  endproperty
  a_sum_read: assert property (p_sum_read) else $error("summary byte bad");

  property p_off_bit;
    @(posedge ref_clk) disable iff (!rst_b)
      rd_sum && !converter_enabled |=> rsp_data[6];
  endproperty
  a_off_bit: assert property (p_off_bit) else $error("off bit not set");

  property p_pgood;
    @(posedge ref_clk) disable iff (!rst_b)
      rd_sum && cmd_word && !power_good |=> rsp_data[11] && rsp_data[13:12] == 2'b00;
  endproperty
  a_pgood: assert property (p_pgood) else $error("power good bit wrong");

  property p_vf_read;
    @(posedge ref_clk) disable iff (!rst_b)
      rd_vf |=> rsp_data[15:8] == 8'h00 && rsp_data[6:5] == 2'b00 && rsp_data[3:0] == 4'h0;
  endproperty
  a_vf_read: assert property (p_vf_read) else $error("output_voltage_alert_flag fault byte bad");

  property p_invalid_alert;
    @(posedge ref_clk) disable iff (!rst_b)
      invalid_wr |=> !smbalert_n_oe && comm_fault_detail[6] && flags_ff[4];
  endproperty
  a_invalid_alert: assert property (p_invalid_alert) else $error("invalid data not flagged");

  property p_save;
    @(posedge ref_clk) disable iff (!rst_b)
      do_save |=> nvm_save && nvm_save_data == $past(rise_word);
  endproperty
  a_save: assert property (p_save) else $error("save did not copy rise time");

  property p_rise_upper;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_rise |-> ##2 !rise_time_word[5];
  endproperty
  a_rise_upper: assert property (p_rise_upper) else $error("upper mantissa bit set");

  property p_snap;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_rise |-> ##2 rise_time_word[4:0] inside {5'h00, 5'h0a, 5'h0e, 5'h13, 5'h1d, 5'h1f};
  endproperty
  a_snap: assert property (p_snap) else $error("rise time not on a setting");

  property p_no_ramp;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_rise && cmd_wdata[4:0] == 5'h00 |-> ##2 rise_no_ramp;
  endproperty
  a_no_ramp: assert property (p_no_ramp) else $error("zero rise time not flagged");

  property p_status_ro;
    @(posedge ref_clk) disable iff (!rst_b)
      cmd_valid && cmd_write && !wr_rise && !do_clear && raw_ev == 11'h000
        |=> flags_ff == $past(flags_ff);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("write altered a flag");

  property p_no_write_rsp;
    @(posedge ref_clk) disable iff (!rst_b)
      cmd_valid && cmd_write |=> !rsp_valid;
  endproperty
  a_no_write_rsp: assert property (p_no_write_rsp) else $error("write answered");

  property p_clear;
    @(posedge ref_clk) disable iff (!rst_b)
      do_clear && raw_ev == 11'h000 |=> flags_ff == 11'h000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left a flag set");

  property p_hold;
    @(posedge ref_clk) disable iff (!rst_b)
      !do_clear |=> (flags_ff & $past(flags_ff)) == $past(flags_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without clear");

  property p_temp;
    @(posedge ref_clk) disable iff (!rst_b)
      temp_fault || temp_warning |=> flags_ff[3];
  endproperty
  a_temp: assert property (p_temp) else $error("temperature flag missing");

  property p_iout;
    @(posedge ref_clk) disable iff (!rst_b)
      output_overcurrent_flag_fault || output_overcurrent_flag_warning |=> flags_ff[7];
  endproperty
  a_iout: assert property (p_iout) else $error("current summary flag missing");

  property p_comm;
    @(posedge ref_clk) disable iff (!rst_b)
      comm_fault |=> flags_ff[4];
  endproperty
  a_comm: assert property (p_comm) else $error("comm flag missing");

  c_write_rise: cover property (@(posedge ref_clk) disable iff (!rst_b) wr_rise ##2 rd_rise);
  c_clear: cover property (@(posedge ref_clk) disable iff (!rst_b) flags_ff[0] ##1 do_clear);
  c_word_read: cover property (@(posedge ref_clk) disable iff (!rst_b) rd_sum && cmd_word);
  c_invalid: cover property (@(posedge ref_clk) disable iff (!rst_b) invalid_wr);
  c_save: cover property (@(posedge ref_clk) disable iff (!rst_b) do_save ##1 nvm_save);

endmodule

// ==== softstart_time_and_fault_status_test.sv ====
// Purpose: self-checking bench for the rise-time and fault status commands
// Assumes: host model drives the command port, bench drives fault events
// Notes:   responses are sampled 1 ns after the edge that takes the strobe
module softstart_time_and_fault_status_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk;
  logic        rst_b;
  logic        converter_enabled;
  logic        power_good;
  logic [9:0]  ev;
  logic        cmd_valid;
  logic        cmd_write;
  logic        cmd_word;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic [15:0] rise_time_word;
  logic [2:0]  rise_setting;
  logic        rise_no_ramp;
  logic        nvm_save;
  logic [15:0] nvm_save_data;
  logic [7:0]  comm_fault_detail;
  logic        smbalert_n_oe;
  logic        v;
  logic [15:0] d;
  int          fail_count = 0;
  int          cmp_count = 0;
  // expected summary word per event: ov, uv, vwarn, ocf, ocw, vin, tf, tw, comm, other
  localparam logic [15:0] EXP_EV [10] = '{16'h8020, 16'h8001, 16'h8000, 16'h4010,
    16'h4001, 16'h0008, 16'h0004, 16'h0004, 16'h0002, 16'h0001};
  localparam logic [4:0] MANT [4] = '{5'h0a, 5'h0e, 5'h13, 5'h1d};
  // expected output-voltage fault byte per event, same order
  localparam logic [15:0] EXP_VF [10] = '{16'h0080, 16'h0010, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  ////////////////////////////////////////////////////////////////////////////////
  host_cmd_model i_host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_word(cmd_word), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));

  softstart_time_and_fault_status i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_word(cmd_word),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .converter_enabled(converter_enabled),
    .power_good(power_good), .output_voltage_alert_flag_above_ov_trip(ev[0]), .output_voltage_alert_flag_below_uv_trip(ev[1]),
    .output_voltage_alert_flag_warning(ev[2]), .output_overcurrent_flag_fault(ev[3]), .output_overcurrent_flag_warning(ev[4]),
    .input_undervoltage_flag_fault(ev[5]), .temp_fault(ev[6]), .temp_warning(ev[7]),
    .comm_fault(ev[8]), .other_fault(ev[9]), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rise_time_word(rise_time_word), .rise_setting(rise_setting),
    .rise_no_ramp(rise_no_ramp), .nvm_save(nvm_save), .nvm_save_data(nvm_save_data),
    .comm_fault_detail(comm_fault_detail), .smbalert_n_oe(smbalert_n_oe));

  ////////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // a read must answer exactly one cycle after the strobe
  task automatic rd(input logic [7:0] code, input logic wd, input logic [15:0] exp);
    i_host.xfer(1'b0, wd, code, 16'h0000, v, d);
    chk({15'h0, v}, 16'h0001);
    chk(d, exp);
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    i_host.xfer(1'b1, 1'b0, code, data, v, d);
  endtask

  // the rise word and no-ramp outputs trail the stored mantissa by one cycle
  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // watchdog: whole sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_b = 1'b0;
    converter_enabled = 1'b1;
    power_good = 1'b1;
    ev = 10'h000;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk(rise_time_word, 16'he02b);
    chk({13'h0, rise_setting}, 16'h0004);
    chk({15'h0, smbalert_n_oe}, 16'h0001);
    rd(ssfault_pkg::CMD_RISE_TIME, 1'b0, 16'he02b);
    rd(ssfault_pkg::CMD_SUMMARY, 1'b1, 16'h0000);
    rd(ssfault_pkg::CMD_OUTPUT_VOLTAGE_ALERT_FLAG_FAULTS, 1'b0, 16'h0000);
    $display("test reset values done");
    // the four lowest supported values land on their own setting, no alert
    for (int i = 0; i < 4; i++) begin
      wr(ssfault_pkg::CMD_RISE_TIME, {5'h1c, 6'h00, MANT[i]});
      chk({13'h0, rise_setting}, 16'(i));
      settle();
      chk(rise_time_word, {5'h1c, 6'h00, MANT[i]});
      chk({15'h0, smbalert_n_oe}, 16'h0001);
    end
    // an off-table value snaps to the nearest setting and is flagged
    wr(ssfault_pkg::CMD_RISE_TIME, 16'he011);
    settle();
    chk(rise_time_word, 16'he013);
    chk({13'h0, rise_setting}, 16'h0002);
    chk({15'h0, smbalert_n_oe}, 16'h0000);
    rd(ssfault_pkg::CMD_RISE_TIME, 1'b0, 16'he013);
    wr(ssfault_pkg::CMD_CLEAR_FAULTS, 16'h0000);
    chk({15'h0, smbalert_n_oe}, 16'h0001);
    // exponent and upper mantissa bits cannot be written; flagged as invalid
    wr(ssfault_pkg::CMD_RISE_TIME, 16'hffea);
    settle();
    chk(rise_time_word, 16'he00a);
    chk({8'h0, comm_fault_detail}, 16'h0040);
    chk({15'h0, smbalert_n_oe}, 16'h0000);
    rd(ssfault_pkg::CMD_SUMMARY, 1'b0, 16'h0002);
    wr(ssfault_pkg::CMD_CLEAR_FAULTS, 16'h0000);
    chk({8'h0, comm_fault_detail}, 16'h0000);
    chk({15'h0, smbalert_n_oe}, 16'h0001);
    wr(ssfault_pkg::CMD_RISE_TIME, 16'he000);
    settle();
    chk({15'h0, rise_no_ramp}, 16'h0001);
    chk(rise_time_word, 16'he000);
    // both save codes pulse once and carry the current word
    for (int i = 0; i < 2; i++) begin
      wr(i == 0 ? ssfault_pkg::CMD_SAVE_ALL : ssfault_pkg::CMD_SAVE_CODE, 16'h0000);
      chk({15'h0, nvm_save}, 16'h0001);
      chk(nvm_save_data, 16'he000);
      settle();
      chk({15'h0, nvm_save}, 16'h0000);
    end
    $display("test rise time done");
    // each event pulses one cycle, stays latched, ignores writes, clears
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      ev <= 10'(1 << i);
      @(posedge ref_clk);
      ev <= 10'h000;
      rd(ssfault_pkg::CMD_SUMMARY, 1'b1, EXP_EV[i]);
      rd(ssfault_pkg::CMD_SUMMARY, 1'b0, {8'h00, EXP_EV[i][7:0]});
      rd(ssfault_pkg::CMD_OUTPUT_VOLTAGE_ALERT_FLAG_FAULTS, 1'b0, EXP_VF[i]);
      wr(ssfault_pkg::CMD_SUMMARY, 16'h0000);
      chk({15'h0, v}, 16'h0000);
      wr(ssfault_pkg::CMD_OUTPUT_VOLTAGE_ALERT_FLAG_FAULTS, 16'h0000);
      rd(ssfault_pkg::CMD_SUMMARY, 1'b1, EXP_EV[i]);
      wr(ssfault_pkg::CMD_CLEAR_FAULTS, 16'h0000);
      rd(ssfault_pkg::CMD_SUMMARY, 1'b1, 16'h0000);
    end
    $display("test fault flags done");
    // live off and power-good bits follow their inputs
    @(posedge ref_clk);
    converter_enabled <= 1'b0;
    rd(ssfault_pkg::CMD_SUMMARY, 1'b0, 16'h0040);
    @(posedge ref_clk);
    power_good <= 1'b0;
    rd(ssfault_pkg::CMD_SUMMARY, 1'b1, 16'h0840);
    @(posedge ref_clk);
    converter_enabled <= 1'b1;
    power_good <= 1'b1;
    rd(ssfault_pkg::CMD_SUMMARY, 1'b1, 16'h0000);
    $display("test live bits done");
    conclude();
  end
endmodule

// ==== ssfault_pkg.sv ====
// Purpose: shared constants for the soft-start time and fault status command logic
// Assumes: commands arrive on a simple synchronous command port from the bus front end
// Notes:   command codes are byte wide; data words are 16 bits, low byte first on the wire
package ssfault_pkg;

  // command codes
  localparam logic [7:0]  CMD_RISE_TIME      = 8'h61;
  localparam logic [7:0]  CMD_SUMMARY        = 8'h78;
  localparam logic [7:0]  CMD_OUTPUT_VOLTAGE_ALERT_FLAG_FAULTS    = 8'h7a;
  localparam logic [7:0]  CMD_CLEAR_FAULTS   = 8'h03;
  localparam logic [7:0]  CMD_SAVE_ALL       = 8'h11;
  localparam logic [7:0]  CMD_SAVE_CODE      = 8'h12;

  // rise-time word layout
  localparam logic [4:0]  RISE_EXPONENT      = 5'h1c;
  localparam logic [4:0]  RISE_RESET_MANT    = 5'h0b;
  localparam logic [15:0] RISE_RESET_WORD    = 16'he02b;
  localparam int          RISE_MANT_BITS     = 5;
  localparam int          RISE_SETTINGS      = 8;

  // summary byte bit positions
  localparam int          SB_OFF             = 6;
  localparam int          SB_OUTPUT_OVERVOLTAGE_FLAG         = 5;
  localparam int          SB_OUTPUT_OVERCURRENT_FLAG         = 4;
  localparam int          SB_INPUT_UNDERVOLTAGE_FLAG          = 3;
  localparam int          SB_TEMP            = 2;
  localparam int          SB_CML             = 1;
  localparam int          SB_OTHER           = 0;

  // summary word high byte positions
  localparam int          SW_OUTPUT_VOLTAGE_ALERT_FLAG            = 7;
  localparam int          SW_IOUT            = 6;
  localparam int          SW_PGOOD_N         = 3;

  // output-voltage fault bit positions
  localparam int          VF_OV              = 7;
  localparam int          VF_UV              = 4;

  // comm detail bit for invalid data
  localparam int          CML_INVALID_DATA   = 6;

  // reset values of status storage
  localparam logic [7:0]  STATUS_RESET       = 8'h00;

  // clock and nominal soft-start stretch
  localparam int          CLK_HZ             = 25000000;
  localparam int          STRETCH_PERCENT    = 15;
  localparam int          RAMP_US_PER_UNIT   = 1;

  // supported rise-time table in microseconds, index 0 fastest
  localparam int          RISE_US_0          = 600;
  localparam int          RISE_US_1          = 900;
  localparam int          RISE_US_2          = 1200;
  localparam int          RISE_US_3          = 1800;
  localparam int          RISE_US_4          = 2700;
  localparam int          RISE_US_5          = 4200;
  localparam int          RISE_US_6          = 6000;
  localparam int          RISE_US_7          = 9000;

endpackage
